// ==== asc_cfg_if.sv ====
`timescale 1ns/1ps
interface asc_cfg_if;
   logic [asc_pkg::ASC_MUX_SPAN-1:0] input_select;
   logic [asc_pkg::ASC_CTL_W-1:0]    sample_control;
   modport bank
   (
      output input_select,
      output sample_control
   );
   modport walker
   (
      input input_select,
      input sample_control
   );
endinterface

// ==== asc_cfg_properties.sv ====
`timescale 1ns/1ps
module asc_cfg_properties
(
   input wire logic            clk,
   input wire logic            resetn,
   input wire logic            rd,
   input wire logic [31:0]     rdata,
   input wire logic [1:0]      seq_start,
   input wire logic [1:0]      sample_done,
   input wire logic [1:0]      seq_active,
   input wire logic [1:0][1:0] seq_step,
   input wire logic [1:0][1:0] step_input_chooser,
   input wire logic [1:0]      step_sequence_last_flag,
   input wire logic [1:0]      seq_done
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!resetn);
   a_rsvd_read_zero: assert property ($past(rd) |-> rdata[31:16] == 16'h0000) else $error("reserved bits");
   a_idle_settings_zero: assert property (!seq_active[0] |-> step_input_chooser[0] == 2'h0
      && !step_sequence_last_flag[0]) else $error("idle settings");
   a_start_first_step: assert property (!seq_active[1] && seq_start[1]
      |=> seq_active[1] && seq_step[1] == 2'h0) else $error("start");
   a_step_advance: assert property (seq_active[0] && sample_done[0] && !step_sequence_last_flag[0]
      && seq_step[0] != 2'h3 |=> seq_step[0] == $past(seq_step[0]) + 2'h1) else $error("advance");
   a_last_step_ends: assert property (seq_active[0] && sample_done[0] && step_sequence_last_flag[0]
      |=> seq_done[0] && !seq_active[0]) else $error("end");
   a_done_single: assert property (seq_done[0] |=> !seq_done[0]) else $error("done pulse");
endmodule
bind asc_seq_mid_config_regs asc_cfg_properties chk (.clk(clk), .resetn(resetn), .rd(rd), .rdata(rdata),
   .seq_start(seq_start), .sample_done(sample_done), .seq_active(seq_active), .seq_step(seq_step),
   .step_input_chooser(step_input_chooser), .step_sequence_last_flag(step_sequence_last_flag),
   .seq_done(seq_done));

// ==== asc_pkg.sv ====
package asc_pkg;
   localparam int ASC_ADDR_W = 12;
   localparam int ASC_DATA_W = 32;
   localparam int ASC_SEQS   = 2;
   localparam int ASC_STEPS  = 4;
   localparam logic [ASC_ADDR_W-1:0] ASC_SEQ1_INPUT_SELECT_OFS   = 12'h060;
   localparam logic [ASC_ADDR_W-1:0] ASC_SEQ1_SAMPLE_CONTROL_OFS = 12'h064;
   localparam logic [ASC_ADDR_W-1:0] ASC_SEQ2_INPUT_SELECT_OFS   = 12'h080;
   localparam logic [ASC_ADDR_W-1:0] ASC_SEQ2_SAMPLE_CONTROL_OFS = 12'h084;
   localparam int ASC_MUX_W     = 2;
   localparam int ASC_MUX_SPAN  = 14;
   localparam int ASC_CTL_W     = 16;
   localparam int ASC_GROUP_W   = 4;
   localparam int ASC_PAIR_POS  = 0;
   localparam int ASC_LAST_POS  = 1;
   localparam int ASC_IRQ_POS   = 2;
   localparam int ASC_TEMP_POS  = 3;
   localparam logic [ASC_MUX_SPAN-1:0] ASC_INPUT_SELECT_RST   = 14'h0000;
   localparam logic [ASC_CTL_W-1:0]    ASC_SAMPLE_CONTROL_RST = 16'h0000;
   localparam logic [1:0]              ASC_LAST_STEP          = 2'h3;
   typedef logic [1:0] asc_step_t;
endpackage

// ==== asc_seq_mid_config_regs.sv ====
`timescale 1ns/1ps
module asc_seq_mid_config_regs
(
   input  wire logic                            clk,
   input  wire logic                            resetn,
   input  wire logic [asc_pkg::ASC_ADDR_W-1:0]  addr,
   input  wire logic [asc_pkg::ASC_DATA_W-1:0]  wdata,
   input  wire logic                            wr,
   input  wire logic                            rd,
   output logic [asc_pkg::ASC_DATA_W-1:0]       rdata,
   input  wire logic [1:0]                      seq_start,
   input  wire logic [1:0]                      sample_done,
   output logic [1:0]                           seq_active,
   output logic [1:0][1:0]                      seq_step,
   output logic [1:0][1:0]                      step_input_chooser,
   output logic [1:0]                           step_temp_sensor_select,
   output logic [1:0]                           step_irq_enable,
   output logic [1:0]                           step_sequence_last_flag,
   output logic [1:0]                           step_pair_input_select,
   output logic [1:0]                           seq_done
);
   typedef struct packed {
      logic [1:0][asc_pkg::ASC_MUX_SPAN-1:0] input_select;
      logic [1:0][asc_pkg::ASC_CTL_W-1:0]    sample_control;
      logic [asc_pkg::ASC_DATA_W-1:0]        rdata;
   } asc_bank_t;

   asc_bank_t s_r;
   asc_bank_t s_nxt;

   // only step fields are writable; gaps stay zero
   localparam logic [asc_pkg::ASC_MUX_SPAN-1:0] MUX_WMASK = 14'h3333;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.rdata = '0;
      if (wr)
      begin
         case (addr)
            asc_pkg::ASC_SEQ1_INPUT_SELECT_OFS:
               s_nxt.input_select[0] = wdata[asc_pkg::ASC_MUX_SPAN-1:0] & MUX_WMASK;
            asc_pkg::ASC_SEQ1_SAMPLE_CONTROL_OFS:
               s_nxt.sample_control[0] = wdata[asc_pkg::ASC_CTL_W-1:0];
            asc_pkg::ASC_SEQ2_INPUT_SELECT_OFS:
               s_nxt.input_select[1] = wdata[asc_pkg::ASC_MUX_SPAN-1:0] & MUX_WMASK;
            asc_pkg::ASC_SEQ2_SAMPLE_CONTROL_OFS:
               s_nxt.sample_control[1] = wdata[asc_pkg::ASC_CTL_W-1:0];
            default:
               s_nxt.rdata = '0;
         endcase
      end
      if (rd)
      begin
         case (addr)
            asc_pkg::ASC_SEQ1_INPUT_SELECT_OFS:
               s_nxt.rdata = {18'h00000, s_r.input_select[0]};
            asc_pkg::ASC_SEQ1_SAMPLE_CONTROL_OFS:
               s_nxt.rdata = {16'h0000, s_r.sample_control[0]};
            asc_pkg::ASC_SEQ2_INPUT_SELECT_OFS:
               s_nxt.rdata = {18'h00000, s_r.input_select[1]};
            asc_pkg::ASC_SEQ2_SAMPLE_CONTROL_OFS:
               s_nxt.rdata = {16'h0000, s_r.sample_control[1]};
            default:
               s_nxt.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         s_r.input_select[0]   <= asc_pkg::ASC_INPUT_SELECT_RST;
         s_r.input_select[1]   <= asc_pkg::ASC_INPUT_SELECT_RST;
         s_r.sample_control[0] <= asc_pkg::ASC_SAMPLE_CONTROL_RST;
         s_r.sample_control[1] <= asc_pkg::ASC_SAMPLE_CONTROL_RST;
         s_r.rdata             <= '0;
      end
      else
         s_r <= s_nxt;
   end

   assign rdata = s_r.rdata;

   genvar g;
   generate
      for (g = 0; g < asc_pkg::ASC_SEQS; g++)
      begin : seq
         asc_cfg_if cfg ();
         assign cfg.input_select   = s_r.input_select[g];
         assign cfg.sample_control = s_r.sample_control[g];
         asc_step_walker u_walk
         (
            .clk                (clk),
            .resetn             (resetn),
            .cfg                (cfg),
            .start              (seq_start[g]),
            .sample_done        (sample_done[g]),
            .active             (seq_active[g]),
            .step               (seq_step[g]),
            .input_chooser      (step_input_chooser[g]),
            .temp_sensor_select (step_temp_sensor_select[g]),
            .irq_enable         (step_irq_enable[g]),
            .sequence_last_flag (step_sequence_last_flag[g]),
            .pair_input_select  (step_pair_input_select[g]),
            .done               (seq_done[g])
         );
      end
   endgenerate
endmodule

// ==== asc_step_walker.sv ====
`timescale 1ns/1ps
module asc_step_walker
(
   input  wire logic             clk,
   input  wire logic             resetn,
   asc_cfg_if.walker             cfg,
   input  wire logic             start,
   input  wire logic             sample_done,
   output logic                  active,
   output asc_pkg::asc_step_t    step,
   output logic [1:0]            input_chooser,
   output logic                  temp_sensor_select,
   output logic                  irq_enable,
   output logic                  sequence_last_flag,
   output logic                  pair_input_select,
   output logic                  done
);
   typedef struct packed {
      logic               active;
      asc_pkg::asc_step_t step;
      logic [1:0]         chooser;
      logic               temp;
      logic               irq;
      logic               last;
      logic               pair;
      logic               done;
   } asc_walk_t;

   asc_walk_t s_r;
   asc_walk_t s_nxt;

   always_comb
   begin
      logic [3:0] sel;
      logic [3:0] grp;
      sel = 4'h0;
      grp = 4'h0;
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      if (!s_r.active)
      begin
         if (start)
         begin
            s_nxt.active = 1'b1;
            s_nxt.step = 2'h0;
         end
      end
      else if (sample_done)
      begin
         // stop at first flagged step, or after the fourth regardless
         if (s_r.last || s_r.step == asc_pkg::ASC_LAST_STEP)
         begin
            s_nxt.active = 1'b0;
            s_nxt.done = 1'b1;
         end
         else
         begin
            s_nxt.step = s_r.step + 2'h1;
         end
      end
      sel = {s_nxt.step, 2'b00};
      grp = cfg.sample_control[sel +: asc_pkg::ASC_GROUP_W];
      if (s_nxt.active)
      begin
         s_nxt.chooser = cfg.input_select[sel +: asc_pkg::ASC_MUX_W];
         s_nxt.temp = grp[asc_pkg::ASC_TEMP_POS];
         s_nxt.irq = grp[asc_pkg::ASC_IRQ_POS];
         s_nxt.last = grp[asc_pkg::ASC_LAST_POS];
         s_nxt.pair = grp[asc_pkg::ASC_PAIR_POS];
      end
      else
      begin
         s_nxt.chooser = 2'h0;
         s_nxt.temp = 1'b0;
         s_nxt.irq = 1'b0;
         s_nxt.last = 1'b0;
         s_nxt.pair = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign active             = s_r.active;
   assign step               = s_r.step;
   assign input_chooser      = s_r.chooser;
   assign temp_sensor_select = s_r.temp;
   assign irq_enable         = s_r.irq;
   assign sequence_last_flag = s_r.last;
   assign pair_input_select  = s_r.pair;
   assign done               = s_r.done;
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
   logic             clk, resetn, wr, rd;
   logic [11:0]      addr;
   logic [31:0]      wdata, rdata;
   logic [1:0]       seq_start, sample_done, seq_active, seq_done;
   logic [1:0]       step_temp_sensor_select, step_irq_enable, step_sequence_last_flag, step_pair_input_select;
   logic [1:0][1:0]  seq_step, step_input_chooser;
   int               err_count, checked;
   logic [11:0]      ofs [4] = '{12'h060, 12'h064, 12'h080, 12'h084};
   asc_seq_mid_config_regs uut (.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .seq_start, .sample_done,
      .seq_active, .seq_step, .step_input_chooser, .step_temp_sensor_select, .step_irq_enable,
      .step_sequence_last_flag, .step_pair_input_select, .seq_done);
   task automatic end_of_test;
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr_reg(logic [11:0] a, logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(logic [11:0] a, logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("rdata", e, rdata);
   endtask
   // one sequence: each step's settings, then the end pulse
   task automatic run(int g, logic [13:0] m, logic [15:0] c);
      int n;
      n = 0;
      @(posedge clk);
      seq_start[g] <= 1'b1;
      @(posedge clk);
      seq_start[g] <= 1'b0;
      #1;
      while (n < 4)
      begin
         chk("active", 32'h1, seq_active[g]);
         chk("step", n, seq_step[g]);
         chk("input", m[4*n+:2], step_input_chooser[g]);
         chk("group", c[4*n+:4], {step_temp_sensor_select[g], step_irq_enable[g],
            step_sequence_last_flag[g], step_pair_input_select[g]});
         @(posedge clk);
         sample_done[g] <= 1'b1;
         @(posedge clk);
         sample_done[g] <= 1'b0;
         #1;
         n = c[4*n+1] ? 4 : n + 1;
      end
      chk("done", 32'h1, seq_done[g]);
      chk("active", 32'h0, seq_active[g]);
      chk("idle", 32'h0, {step_input_chooser[g], step_temp_sensor_select[g], step_irq_enable[g],
         step_sequence_last_flag[g], step_pair_input_select[g]});
      @(posedge clk);
      #1;
      chk("done", 32'h0, seq_done[g]);
   endtask
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      #20000;
      err_count++;
      end_of_test;
   end
   initial
   begin
      err_count = 0;
      checked = 0;
      resetn = 1'b0;
      addr = 12'h000;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      seq_start = 2'h0;
      sample_done = 2'h0;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      for (int i = 0; i < 4; i++)
         rd_chk(ofs[i], 32'h0);
      for (int i = 0; i < 4; i++)
         wr_reg(ofs[i], 32'hffffffff);
      for (int i = 0; i < 4; i++)
         rd_chk(ofs[i], i[0] ? 32'h0000ffff : 32'h00003333);
      wr_reg(12'h070, 32'hffffffff);
      rd_chk(12'h070, 32'h0);
      wr_reg(12'h060, 32'h2130);
      wr_reg(12'h064, 32'hfc95);
      run(0, 14'h2130, 16'hfc95);
      wr_reg(12'h080, 32'h1023);
      wr_reg(12'h084, 32'h7f2c);
      run(1, 14'h1023, 16'h7f2c);
      rd_chk(12'h064, 32'h0000fc95);
      end_of_test;
   end
endmodule
